// ==== common/dac_cfg_pkg.sv ====
`default_nettype none
package dac_cfg_pkg;
   localparam int          ADDR_W         = 7;
   localparam int          DATA_W         = 16;
   localparam int          FRAME_BITS     = 24;
   localparam int          CHANNELS       = 4;
   localparam logic [6:0]  GEN_CFG_A_ADDR = 7'h00;
   localparam logic [6:0]  IF_CFG_ADDR    = 7'h01;
   localparam logic [6:0]  SHUT_MIX_ADDR  = 7'h02;
   localparam logic [15:0] GEN_CFG_A_RST  = 16'h049c;
   localparam logic [15:0] IF_CFG_RST     = 16'h040e;
   localparam logic [15:0] SHUT_MIX_RST   = 16'h7000;
   localparam logic [15:0] IF_CFG_WMASK   = 16'h9ffe;
   localparam logic [15:0] SHUT_MIX_WMASK = 16'h70fa;
   // Interface configuration fields
   localparam int          PATTERN_BIT    = 15;
   localparam int          AUTO_CLR_BIT   = 12;
   localparam int          ODD_PAR_BIT    = 11;
   localparam int          PAR_ON_BIT     = 10;
   localparam int          DUAL_PAR_BIT   = 9;
   localparam int          ROTATE_BIT     = 8;
   localparam int          INVERT_LSB     = 4;
   localparam int          TWO_FLAG_BIT   = 3;
   localparam int          ONE_FLAG_BIT   = 2;
   localparam int          COLL_FLAG_BIT  = 1;
   // Shutdown and mixing fields
   localparam int          DACCLK_SD_BIT  = 14;
   localparam int          DATACLK_SD_BIT = 13;
   localparam int          COLL_SD_BIT    = 12;
   localparam int          FOUR_WIRE_BIT  = 7;
   localparam int          MIXER_BIT      = 6;
   localparam int          MIX_GAIN_BIT   = 5;
   localparam int          NCO_BIT        = 4;
   localparam int          REV_BUS_BIT    = 3;
   localparam int          TWOS_BIT       = 1;
   // FIFO pointer alarm codes and auto-clear run
   localparam logic [2:0]  FIFO_TWO_AWAY  = 3'h1;
   localparam int          GOOD_RUN       = 64;
   localparam logic [6:0]  GOOD_LAST      = 7'(GOOD_RUN - 1);
endpackage : dac_cfg_pkg
`default_nettype wire

// ==== core/serial_port_slave.sv ====
`default_nettype none
module serial_port_slave (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_sclk,
   input  wire logic        i_sden_n,
   input  wire logic        i_sdio,
   input  wire logic        i_four_wire,
   input  wire logic [15:0] i_rd_data,
   output logic             o_sdio,
   output logic             o_sdio_oe_n,
   output logic             o_sdo,
   output logic [6:0]       o_addr,
   output logic [15:0]      o_wr_data,
   output logic             o_wr_pulse
);
   logic        sclk_m, sclk_s, sclk_p, en_m, en_s, dio_m, dio_s;
   logic [4:0]  cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d, wdata_q, wdata_d;
   logic [6:0]  addr_q, addr_d;
   logic        rd_q, rd_d, dout_q, dout_d, oe_n_q, oe_n_d, wr_q, wr_d;
   logic        rise, fall;

   always_ff @(posedge i_clk_sys) begin
      sclk_m <= i_sclk;
      sclk_s <= sclk_m;
      sclk_p <= sclk_s;
      en_m   <= i_sden_n;
      en_s   <= en_m;
      dio_m  <= i_sdio;
      dio_s  <= dio_m;
   end

   assign rise = sclk_s & ~sclk_p;
   assign fall = ~sclk_s & sclk_p;

   always_comb begin
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      addr_d  = addr_q;
      rd_d    = rd_q;
      dout_d  = dout_q;
      oe_n_d  = oe_n_q;
      wdata_d = wdata_q;
      wr_d    = 1'b0;
      if (en_s) begin
         cnt_d  = 5'h00;
         rd_d   = 1'b0;
         oe_n_d = 1'b1;
      end else begin
         if (rise && cnt_q < 5'(dac_cfg_pkg::FRAME_BITS)) begin
            sh_d  = {sh_q[14:0], dio_s};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'h07) begin
               rd_d   = sh_q[6];
               addr_d = {sh_q[5:0], dio_s};
            end
            if (cnt_q == 5'h17 && !rd_q) begin
               wr_d    = 1'b1;
               wdata_d = {sh_q[14:0], dio_s};
            end
         end
         // Read data leaves on falling edges, MSB first
         if (fall && rd_q && cnt_q >= 5'h08 && cnt_q <= 5'h17) begin
            dout_d = i_rd_data[4'(5'h17 - cnt_q)];
            oe_n_d = i_four_wire;  // see R13
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         cnt_q   <= 5'h00;
         sh_q    <= 16'h0000;
         addr_q  <= 7'h00;
         rd_q    <= 1'b0;
         dout_q  <= 1'b0;
         oe_n_q  <= 1'b1;
         wdata_q <= 16'h0000;
         wr_q    <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         addr_q  <= addr_d;
         rd_q    <= rd_d;
         dout_q  <= dout_d;
         oe_n_q  <= oe_n_d;
         wdata_q <= wdata_d;
         wr_q    <= wr_d;
      end
   end

   assign o_sdio      = dout_q;
   assign o_sdo       = dout_q;
   assign o_sdio_oe_n = oe_n_q;
   assign o_addr      = addr_q;
   assign o_wr_data   = wdata_q;
   assign o_wr_pulse  = wr_q;
endmodule : serial_port_slave
`default_nettype wire

// ==== core/input_word_checker.sv ====
`default_nettype none
module input_word_checker #(
   parameter int CH = 4
) (
   input  wire logic            i_clk_sys,
   input  wire logic            i_reset,
   input  wire logic [CH*16-1:0] i_words,
   input  wire logic            i_parity_pair,
   input  wire logic            i_sync_pair,
   input  wire logic            i_sample_strobe_pair,
   input  wire logic            i_rotate,
   input  wire logic            i_rev_bus,
   input  wire logic            i_parity_on,
   input  wire logic            i_odd_parity,
   input  wire logic            i_dual_parity,
   input  wire logic            i_twos,
   input  wire logic [CH-1:0]   i_invert,
   output logic [CH*16-1:0]     o_samples,
   output logic                 o_valid,
   output logic                 o_sync,
   output logic                 o_parity_err
);
   localparam int HALF = CH * 8;
   logic [CH*16-1:0] w_m, w_s, smp_d, smp_q;
   logic [2:0]       c_m, c_s;
   logic             strobe, sync_in, par_in, err_d, err_q, val_q, sync_q;

   always_ff @(posedge i_clk_sys) begin
      w_m <= i_words;
      w_s <= w_m;
      c_m <= {i_sample_strobe_pair, i_sync_pair, i_parity_pair};
      c_s <= c_m;
   end

   // Rotated control inputs
   assign strobe  = i_rotate ? c_s[1] : c_s[2];  // see R7
   assign sync_in = i_rotate ? c_s[0] : c_s[1];  // see R7
   assign par_in  = i_rotate ? c_s[2] : c_s[0];  // see R7

   generate
      for (genvar c = 0; c < CH; c++) begin : g_lane
         logic [15:0] raw, ord;
         assign raw = w_s[c*16 +: 16];
         for (genvar b = 0; b < 16; b++) begin : g_bit
            assign ord[b] = i_rev_bus ? raw[15-b] : raw[b];  // see R16
         end
         // Offset-binary is turned to two's complement by its MSB
         assign smp_d[c*16 +: 16] = {ord[15] ^ ~i_twos, ord[14:0]}
                                    ^ {16{i_invert[CH-1-c]}};  // see R17 see R8
      end
   endgenerate

   always_comb begin
      err_d = 1'b0;
      if (i_parity_on) begin  // see R5
         if (i_dual_parity) begin  // see R6
            err_d = ((^w_s[HALF-1:0] ^ par_in) != i_odd_parity) ||
                    ((^w_s[CH*16-1:HALF] ^ par_in) != i_odd_parity);
         end else begin
            err_d = (^w_s ^ par_in) != i_odd_parity;  // see R4
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         smp_q  <= '0;
         val_q  <= 1'b0;
         sync_q <= 1'b0;
         err_q  <= 1'b0;
      end else begin
         smp_q  <= strobe ? smp_d : smp_q;
         val_q  <= strobe;
         sync_q <= sync_in;
         err_q  <= strobe & err_d;
      end
   end

   assign o_samples    = smp_q;
   assign o_valid      = val_q;
   assign o_sync       = sync_q;
   assign o_parity_err = err_q;
endmodule : input_word_checker
`default_nettype wire

// ==== core/dac_input_config_regs.sv ====
// Operation
// R1: Pattern bit enters data pattern checking mode
// R2: Pattern mode forces analog outputs off
// R3: 64 good samples auto-clear alarm flags
// R4: Bit 11 picks even or odd parity
// R5: Bit 10 checks parity of every word
// R6: Dual parity only with parity check on
// R7: Bit 8 rotates strobe, sync, parity inputs
// R8: Bits 7..4 complement channels A to D
// R9: Bits 3..1 enable FIFO pointer alarms
// R10: Converter clock loss shuts outputs if unmasked
// R11: Data clock loss shuts outputs if unmasked
// R12: FIFO collision shuts outputs if unmasked
// R13: Bit 7 selects four or three wire port
// R14: Mixer enable and 6-dB mixer gain
// R15: Oscillator enable, unneeded for coarse mixing
// R16: Bit 3 reverses input data bus order
// R17: Bit 1 selects two's complement input
// R18: Interface register resets to 0x040E
// R19: Second register resets to 0x7000
// R20: Pointer alarm codes; collision needs resync, clear
// R21: Software writes zero to reserved bits
`default_nettype none
module dac_input_config_regs #(
   parameter int CH = dac_cfg_pkg::CHANNELS
) (
   input  wire logic            i_clk_sys,
   input  wire logic            i_reset,
   input  wire logic            i_sclk,
   input  wire logic            i_sden_n,
   input  wire logic            i_sdio,
   output logic                 o_sdio,
   output logic                 o_sdio_oe_n,
   output logic                 o_sdo,
   input  wire logic [CH*16-1:0] i_samples,
   input  wire logic            i_parity_pair,
   input  wire logic            i_sync_pair,
   input  wire logic            i_sample_strobe_pair,
   input  wire logic            i_transmit_pin,
   input  wire logic            i_sif_txenable,
   input  wire logic            i_dacclk_gone,
   input  wire logic            i_dataclk_gone,
   input  wire logic [2:0]      i_fifo_ptr_alarm,
   input  wire logic            i_mask_dacclk_gone,
   input  wire logic            i_mask_dataclk_gone,
   input  wire logic            i_mask_collision,
   input  wire logic            i_mask_output_gone,
   input  wire logic            i_alarm_clear,
   output logic [CH*16-1:0]     o_samples,
   output logic                 o_sample_valid,
   output logic                 o_sync,
   output logic                 o_pattern_mode,
   output logic                 o_output_on,
   output logic                 o_shutdown,
   output logic [2:0]           o_fifo_alarm,
   output logic                 o_parity_alarm,
   output logic                 o_mixer_on,
   output logic                 o_mixer_gain_6db,
   output logic                 o_nco_on,
   output logic                 o_four_wire_port_sel,
   output logic [15:0]          o_general_config_a
);
   logic [15:0] gen_q, gen_d, ifc_q, ifc_d, mix_q, mix_d, rd_data;
   logic [6:0]  addr, good_q, good_d;
   logic [15:0] wr_data;
   logic        wr_pulse, chk_valid, chk_err;
   logic        tx_m, tx_s;
   logic [2:0]  fifo_q, fifo_d, fifo_set;
   logic        par_q, par_d, shut_q, shut_d, on_q, on_d, auto_clr, clr, trig;

   serial_port_slave u_port (
      .i_clk_sys   (i_clk_sys),
      .i_reset     (i_reset),
      .i_sclk      (i_sclk),
      .i_sden_n    (i_sden_n),
      .i_sdio      (i_sdio),
      .i_four_wire (mix_q[dac_cfg_pkg::FOUR_WIRE_BIT]),
      .i_rd_data   (rd_data),
      .o_sdio      (o_sdio),
      .o_sdio_oe_n (o_sdio_oe_n),
      .o_sdo       (o_sdo),
      .o_addr      (addr),
      .o_wr_data   (wr_data),
      .o_wr_pulse  (wr_pulse)
   );

   input_word_checker #(
      .CH (CH)
   ) u_check (
      .i_clk_sys            (i_clk_sys),
      .i_reset              (i_reset),
      .i_words              (i_samples),
      .i_parity_pair        (i_parity_pair),
      .i_sync_pair          (i_sync_pair),
      .i_sample_strobe_pair (i_sample_strobe_pair),
      .i_rotate             (ifc_q[dac_cfg_pkg::ROTATE_BIT]),
      .i_rev_bus            (mix_q[dac_cfg_pkg::REV_BUS_BIT]),
      .i_parity_on          (ifc_q[dac_cfg_pkg::PAR_ON_BIT]),
      .i_odd_parity         (ifc_q[dac_cfg_pkg::ODD_PAR_BIT]),
      .i_dual_parity        (ifc_q[dac_cfg_pkg::DUAL_PAR_BIT]),
      .i_twos               (mix_q[dac_cfg_pkg::TWOS_BIT]),
      .i_invert             (ifc_q[dac_cfg_pkg::INVERT_LSB +: 4]),
      .o_samples            (o_samples),
      .o_valid              (chk_valid),
      .o_sync               (o_sync),
      .o_parity_err         (chk_err)
   );

   always_ff @(posedge i_clk_sys) begin
      tx_m <= i_transmit_pin;
      tx_s <= tx_m;
   end

   // Register file; reserved bits are not stored and read as zero
   always_comb begin
      gen_d = gen_q;
      ifc_d = ifc_q;
      mix_d = mix_q;
      if (wr_pulse) begin
         unique case (addr)
            dac_cfg_pkg::GEN_CFG_A_ADDR: gen_d = wr_data;
            dac_cfg_pkg::IF_CFG_ADDR:    ifc_d = wr_data & dac_cfg_pkg::IF_CFG_WMASK;  // see R21
            dac_cfg_pkg::SHUT_MIX_ADDR:  mix_d = wr_data & dac_cfg_pkg::SHUT_MIX_WMASK;
            default: ;
         endcase
      end
   end

   always_comb begin
      unique case (addr)
         dac_cfg_pkg::GEN_CFG_A_ADDR: rd_data = gen_q;
         dac_cfg_pkg::IF_CFG_ADDR:    rd_data = ifc_q;
         dac_cfg_pkg::SHUT_MIX_ADDR:  rd_data = mix_q;
         default:                     rd_data = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         gen_q <= dac_cfg_pkg::GEN_CFG_A_RST;
         ifc_q <= dac_cfg_pkg::IF_CFG_RST;    // see R18
         mix_q <= dac_cfg_pkg::SHUT_MIX_RST;  // see R19
      end else begin
         gen_q <= gen_d;
         ifc_q <= ifc_d;
         mix_q <= mix_d;
      end
   end

   // Alarm flags, good-run counter, shutdown and output enable
   always_comb begin
      fifo_set[0] = ifc_q[dac_cfg_pkg::COLL_FLAG_BIT] & i_fifo_ptr_alarm[2];  // see R9 see R20
      fifo_set[1] = ifc_q[dac_cfg_pkg::ONE_FLAG_BIT] & ~i_fifo_ptr_alarm[2]
                    & i_fifo_ptr_alarm[1];  // see R9 see R20
      fifo_set[2] = ifc_q[dac_cfg_pkg::TWO_FLAG_BIT]
                    & (i_fifo_ptr_alarm == dac_cfg_pkg::FIFO_TWO_AWAY);  // see R9
      good_d   = good_q;
      auto_clr = 1'b0;
      if (chk_valid) begin
         if (chk_err) begin
            good_d = 7'h00;
         end else if (good_q == dac_cfg_pkg::GOOD_LAST) begin
            good_d   = 7'h00;
            auto_clr = ifc_q[dac_cfg_pkg::AUTO_CLR_BIT];  // see R3
         end else begin
            good_d = good_q + 7'h01;
         end
      end
      clr    = i_alarm_clear | auto_clr;
      // Set wins over clear
      fifo_d = fifo_set | (fifo_q & ~{3{clr}});
      par_d  = chk_err | (par_q & ~clr);
      trig   = ~i_mask_output_gone & (
               (mix_q[dac_cfg_pkg::DACCLK_SD_BIT] & i_dacclk_gone
                & ~i_mask_dacclk_gone) |  // see R10
               (mix_q[dac_cfg_pkg::DATACLK_SD_BIT] & i_dataclk_gone
                & ~i_mask_dataclk_gone) |  // see R11
               (mix_q[dac_cfg_pkg::COLL_SD_BIT] & fifo_set[0]
                & ~i_mask_collision));  // see R12 see R20
      shut_d = trig | (shut_q & ~i_alarm_clear);
      on_d   = (tx_s | i_sif_txenable) & ~ifc_q[dac_cfg_pkg::PATTERN_BIT]
               & ~shut_q;  // see R2
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         fifo_q <= 3'h0;
         par_q  <= 1'b0;
         good_q <= 7'h00;
         shut_q <= 1'b0;
         on_q   <= 1'b0;
      end else begin
         fifo_q <= fifo_d;
         par_q  <= par_d;
         good_q <= good_d;
         shut_q <= shut_d;
         on_q   <= on_d;
      end
   end

   assign o_sample_valid       = chk_valid;
   assign o_pattern_mode       = ifc_q[dac_cfg_pkg::PATTERN_BIT];  // see R1
   assign o_output_on          = on_q;
   assign o_shutdown           = shut_q;
   assign o_fifo_alarm         = fifo_q;
   assign o_parity_alarm       = par_q;
   assign o_mixer_on           = mix_q[dac_cfg_pkg::MIXER_BIT];     // see R14
   assign o_mixer_gain_6db     = mix_q[dac_cfg_pkg::MIX_GAIN_BIT];  // see R14
   assign o_nco_on             = mix_q[dac_cfg_pkg::NCO_BIT];       // see R15
   assign o_four_wire_port_sel = mix_q[dac_cfg_pkg::FOUR_WIRE_BIT];
   assign o_general_config_a   = gen_q;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   property p_pattern_write;
      wr_pulse && addr == dac_cfg_pkg::IF_CFG_ADDR && wr_data[15] |=> o_pattern_mode;
   endproperty
   a_pattern_write: assert property (p_pattern_write) else $error("pattern mode not set"); // see R1

   property p_pattern_off;
      o_pattern_mode |=> !o_output_on;
   endproperty
   a_pattern_off: assert property (p_pattern_off) else $error("output on in pattern mode"); // see R2

   property p_auto_clear;
      chk_valid && !chk_err && good_q == dac_cfg_pkg::GOOD_LAST
      && ifc_q[dac_cfg_pkg::AUTO_CLR_BIT] && fifo_set == 3'h0
      |=> o_fifo_alarm == 3'h0 && !o_parity_alarm;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("auto clear missed"); // see R3

   property p_parity_flag;
      chk_err |=> o_parity_alarm;
   endproperty
   a_parity_flag: assert property (p_parity_flag) else $error("parity flag lost"); // see R5

   property p_collision_flag;
      i_fifo_ptr_alarm[2] && ifc_q[dac_cfg_pkg::COLL_FLAG_BIT] |=> o_fifo_alarm[0];
   endproperty
   a_collision_flag: assert property (p_collision_flag) else $error("collision flag lost"); // see R9

   property p_clk_loss_off;
      i_dacclk_gone && mix_q[dac_cfg_pkg::DACCLK_SD_BIT] && !i_mask_dacclk_gone
      && !i_mask_output_gone |=> o_shutdown ##1 !o_output_on;
   endproperty
   a_clk_loss_off: assert property (p_clk_loss_off) else $error("no shutdown on clock loss"); // see R10

   property p_three_wire;
      !o_sdio_oe_n |-> !o_four_wire_port_sel;
   endproperty
   a_three_wire: assert property (p_three_wire) else $error("shared line driven in 4-wire"); // see R13

   property p_reset_values;
      disable iff (1'b0) i_reset |=> ifc_q == dac_cfg_pkg::IF_CFG_RST
                                    && mix_q == dac_cfg_pkg::SHUT_MIX_RST;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset value"); // see R18

   property p_parity_gate;
      chk_valid && !$past(ifc_q[dac_cfg_pkg::PAR_ON_BIT]) |-> !chk_err;
   endproperty
   a_parity_gate: assert property (p_parity_gate) else $error("parity off error"); // see R6

   property p_dtclk_off;
      i_dataclk_gone && mix_q[dac_cfg_pkg::DATACLK_SD_BIT] && !i_mask_dataclk_gone
      && !i_mask_output_gone |=> o_shutdown;
   endproperty
   a_dtclk_off: assert property (p_dtclk_off) else $error("data clock loss ignored"); // see R11

   property p_coll_off;
      i_fifo_ptr_alarm[2] && ifc_q[dac_cfg_pkg::COLL_FLAG_BIT] && mix_q[dac_cfg_pkg::COLL_SD_BIT]
      && !i_mask_collision && !i_mask_output_gone |=> o_shutdown;
   endproperty
   a_coll_off: assert property (p_coll_off) else $error("collision ignored"); // see R12

   property p_one_away;
      i_fifo_ptr_alarm == 3'h2 && ifc_q[dac_cfg_pkg::ONE_FLAG_BIT] |=> o_fifo_alarm[1];
   endproperty
   a_one_away: assert property (p_one_away) else $error("one-away flag lost"); // see R9

   property p_two_away;
      i_fifo_ptr_alarm == dac_cfg_pkg::FIFO_TWO_AWAY && ifc_q[dac_cfg_pkg::TWO_FLAG_BIT]
      |=> o_fifo_alarm[2];
   endproperty
   a_two_away: assert property (p_two_away) else $error("two-away flag lost"); // see R20

   property p_mix_write;
      wr_pulse && addr == dac_cfg_pkg::SHUT_MIX_ADDR
      |=> {o_mixer_on, o_mixer_gain_6db, o_nco_on}
          == $past(wr_data[dac_cfg_pkg::NCO_BIT +: 3]);
   endproperty
   a_mix_write: assert property (p_mix_write) else $error("mixer bits lost"); // see R14 see R15

   property p_tx_on;
      i_sif_txenable && !o_pattern_mode && !o_shutdown |=> o_output_on;
   endproperty
   a_tx_on: assert property (p_tx_on) else $error("output not enabled"); // see R2

   c_write:    cover property (wr_pulse && addr == dac_cfg_pkg::SHUT_MIX_ADDR);
   c_shutdown: cover property (!o_shutdown ##1 o_shutdown);
   c_autoclr:  cover property (auto_clr && o_parity_alarm);
   c_pattern:  cover property (o_pattern_mode ##1 !o_output_on);
   c_read:     cover property (!o_sdio_oe_n);
endmodule : dac_input_config_regs
`default_nettype wire

// ==== verification/serial_host_model.sv ====
`default_nettype none
module serial_host_model (
   input  wire logic i_clk_sys,
   input  wire logic i_dev_sdio,
   input  wire logic i_dev_sdio_oe_n,
   input  wire logic i_dev_sdo,
   output logic      o_sclk,
   output logic      o_sden_n,
   output logic      o_sdio_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic bit_q = 1'b0;
   logic drive = 1'b1;
   initial begin
      o_sclk   = 1'b0;
      o_sden_n = 1'b1;
   end
   // Released line shows the inverse of the last driven bit
   assign o_sdio_line = !i_dev_sdio_oe_n ? i_dev_sdio : (drive ? bit_q : ~bit_q);
   task automatic half();
      repeat (5) @(posedge i_clk_sys);
      #1;
   endtask : half
   // Frame: read flag, 7-bit address, 16 data bits, MSB first
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wdata,
                       input logic four, output logic [15:0] rdata);
      logic [23:0] frame;
      frame = {rd, addr, wdata};
      rdata = 16'h0000;
      @(posedge i_clk_sys);
      #1;
      o_sden_n = 1'b0;
      for (int i = 0; i < 24; i++) begin
         if (rd && i >= 8) drive = 1'b0;
         else bit_q = frame[23-i];
         half();
         o_sclk = 1'b1;
         if (rd && i >= 8) rdata = {rdata[14:0], four ? i_dev_sdo : o_sdio_line};
         half();
         o_sclk = 1'b0;
      end
      half();
      o_sden_n = 1'b1;
      drive = 1'b1;
      repeat (4) @(posedge i_clk_sys);
      #1;
   endtask : xfer
endmodule : serial_host_model
`default_nettype wire

// ==== verification/test_dac_input_config_regs.sv ====
`default_nettype none
`define CHECK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end
module test_dac_input_config_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk_sys = 1'b0;
   logic        i_reset = 1'b1;
   logic [63:0] samples = 64'h0;
   logic        par = 1'b0, syn = 1'b0, stb = 1'b0, pin = 1'b0, sif_tx = 1'b0;
   logic        dclk_gone = 1'b0, dtclk_gone = 1'b0, clr = 1'b0, four = 1'b0;
   logic [2:0]  fifo = 3'h0;
   logic [3:0]  mask = 4'h0;
   logic [15:0] cfg1 = 16'h040e, cfg2 = 16'h7000, rd_val;
   wire logic   sclk, sden_n, sdio_line, dev_sdio, dev_oe_n, dev_sdo;
   logic [63:0] out_samples;
   logic        out_valid, out_sync, out_pat, out_on, out_sd, out_par_alarm;
   logic        out_mix, out_gain, out_nco, out_four;
   logic [2:0]  out_fifo;
   logic [15:0] out_cfg_a;
   int          err_total = 0, samples_checked = 0, cycles = 0;
   localparam logic [63:0] D0 = 64'h7ffe_8e05_0f81_1230;
   logic [15:0] c1 [5] = '{16'h040e, 16'h0cae, 16'h0e5e, 16'h050e, 16'h0a0e};
   logic [15:0] c2 [5] = '{16'h7000, 16'h700a, 16'h7008, 16'h7002, 16'h7000};

   serial_host_model host (.i_clk_sys(i_clk_sys), .i_dev_sdio(dev_sdio),
      .i_dev_sdio_oe_n(dev_oe_n), .i_dev_sdo(dev_sdo), .o_sclk(sclk),
      .o_sden_n(sden_n), .o_sdio_line(sdio_line));

   dac_input_config_regs #(.CH(4)) uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_sclk(sclk), .i_sden_n(sden_n), .i_sdio(sdio_line), .o_sdio(dev_sdio),
      .o_sdio_oe_n(dev_oe_n), .o_sdo(dev_sdo), .i_samples(samples),
      .i_parity_pair(par), .i_sync_pair(syn), .i_sample_strobe_pair(stb),
      .i_transmit_pin(pin), .i_sif_txenable(sif_tx), .i_dacclk_gone(dclk_gone),
      .i_dataclk_gone(dtclk_gone), .i_fifo_ptr_alarm(fifo),
      .i_mask_dacclk_gone(mask[0]), .i_mask_dataclk_gone(mask[1]),
      .i_mask_collision(mask[2]), .i_mask_output_gone(mask[3]), .i_alarm_clear(clr),
      .o_samples(out_samples), .o_sample_valid(out_valid), .o_sync(out_sync),
      .o_pattern_mode(out_pat), .o_output_on(out_on), .o_shutdown(out_sd),
      .o_fifo_alarm(out_fifo), .o_parity_alarm(out_par_alarm), .o_mixer_on(out_mix),
      .o_mixer_gain_6db(out_gain), .o_nco_on(out_nco), .o_four_wire_port_sel(out_four),
      .o_general_config_a(out_cfg_a));

   initial begin
      forever #10 i_clk_sys = ~i_clk_sys;
   end

   task automatic conclude();
      if (err_total == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         $display("Error at %0t: timeout", $time);
         conclude();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] unused;
      host.xfer(1'b0, a, d, four, unused);
      if (a == dac_cfg_pkg::SHUT_MIX_ADDR) four = d[dac_cfg_pkg::FOUR_WIRE_BIT];
   endtask : wr

   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      host.xfer(1'b1, a, 16'h0000, four, rd_val);
      `CHECK(rd_val, exp)
   endtask : rd_chk

   task automatic cfg(input logic [15:0] a, input logic [15:0] b);
      cfg1 = a;
      cfg2 = b;
      wr(7'h01, a);
      wr(7'h02, b);
   endtask : cfg

   task automatic clear();
      tick(0);
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(3);
   endtask : clear

   // One strobed word, parity made to pass unless bad is set; in dual parity mode only the low half is made to pass
   task automatic send(input logic [63:0] d, input logic bad);
      logic p;
      int   n;
      p = (cfg1[9] ? ^d[31:0] : ^d) ^ cfg1[11] ^ bad;
      tick(1);
      samples = d;
      {syn, stb, par} = cfg1[8] ? {1'b1, p, 1'b0} : {1'b0, 1'b1, p};
      tick(1);
      {syn, stb, par} = 3'b000;
      n = 0;
      while (out_valid !== 1'b1 && n < 10) begin
         tick(1);
         n++;
      end
      `CHECK(out_valid, 1'b1)
      tick(2);
   endtask : send

   function automatic logic [63:0] expect_words(input logic [63:0] d);
      logic [15:0] w;
      for (int c = 0; c < 4; c++) begin
         w = d[c*16 +: 16];
         if (cfg2[3]) w = {<<{w}};
         if (!cfg2[1]) w[15] = ~w[15];
         if (cfg1[7-c]) w = ~w;
         expect_words[c*16 +: 16] = w;
      end
   endfunction : expect_words

   initial begin
      tick(6);
      i_reset = 1'b0;
      tick(4);
      `CHECK(out_cfg_a, 16'h049c)
      rd_chk(7'h01, 16'h040e);
      rd_chk(7'h02, 16'h7000);
      `CHECK({out_pat, out_mix, out_gain, out_nco, out_four}, 5'h00)
      pin = 1'b1;
      sif_tx = 1'b1;
      tick(6);
      `CHECK(out_on, 1'b1)
      wr(7'h01, 16'h840e);
      `CHECK(out_pat, 1'b1)
      `CHECK(out_on, 1'b0)
      wr(7'h01, dac_cfg_pkg::IF_CFG_WMASK);
      rd_chk(7'h01, 16'h9ffe);
      wr(7'h02, dac_cfg_pkg::SHUT_MIX_WMASK);
      rd_chk(7'h02, 16'h70fa);
      `CHECK({out_four, out_mix, out_gain, out_nco}, 4'hf)
      cfg(16'h040e, 16'h7000);
      rd_chk(7'h02, 16'h7000);
      wr(7'h10, 16'h1234);
      rd_chk(7'h10, 16'h0000);
      sif_tx = 1'b0;
      for (int k = 0; k < 3; k++) begin
         for (int en = 0; en < 2; en++) begin
            wr(7'h01, en ? 16'h040e : 16'h040e & ~(16'h0008 >> k));
            fifo = 3'h1 << k;
            tick(4);
            `CHECK(out_fifo, en ? 3'h4 >> k : 3'h0)
            `CHECK(out_sd, 1'(k == 2 && en))
            fifo = 3'h0;
            clear();
         end
      end
      for (int s = 0; s < 2; s++) begin
         for (int m = 0; m < 4; m++) begin
            wr(7'h02, m == 2 ? 16'h7000 & ~(16'h4000 >> s) : 16'h7000);
            mask = m == 1 ? 4'h8 : m == 3 ? 4'h1 << s : 4'h0;
            {dtclk_gone, dclk_gone} = 2'b01 << s;
            tick(3);
            `CHECK(out_sd, 1'(m == 0))
            `CHECK(out_on, 1'(m != 0))
            {dtclk_gone, dclk_gone} = 2'b00;
            mask = 4'h0;
            clear();
            `CHECK(out_sd, 1'b0)
         end
      end
      for (int k = 0; k < 5; k++) begin
         cfg(c1[k], c2[k]);
         send(D0, 1'b0);
         `CHECK(out_samples, expect_words(D0))
         `CHECK(out_par_alarm, 1'b0)
         send(D0 ^ 64'h1, 1'b0);
         `CHECK(out_par_alarm, cfg1[10] & cfg1[9])
         send(D0, 1'b1);
         `CHECK(out_par_alarm, cfg1[10])
         {syn, par} = cfg1[8] ? 2'b01 : 2'b10;
         tick(4);
         `CHECK(out_sync, 1'b1)
         {syn, par} = 2'b00;
         clear();
      end
      cfg(16'h140e, 16'h7000);
      send(D0, 1'b1);
      samples = D0;
      stb = 1'b1;
      tick(40);
      `CHECK(out_par_alarm, 1'b1)
      tick(30);
      stb = 1'b0;
      tick(4);
      `CHECK(out_par_alarm, 1'b0)
      conclude();
   end
endmodule : test_dac_input_config_regs
`default_nettype wire
